// file: design/rtcshf_top.sv
// Register block for key, smooth calibration, time shift and timestamp capture
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`include "rtcshf_defines.svh"
module rtcshf_top
	import rtcshf_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        ce,
	input  wire logic        rstn,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wrData,
	input  wire logic        wrStb,
	input  wire logic        rdStb,
	output logic      [31:0] rdData,
	input  wire logic        writeUnlocked,
	input  wire logic        kernelClockPin,
	input  wire logic        tsEventPin,
	input  wire logic        tsFlagClear,
	input  wire logic [22:0] calTime,
	input  wire logic [15:0] calDate,
	input  wire logic [14:0] syncPrescalerDiv,
	output logic      [7:0]  keyByte,
	output logic             keyStrobe,
	output logic             secondTick,
	output logic             addSecondTick,
	output logic             shiftPendingFlag,
	output logic             shadowSyncFlag,
	output logic             timestampFlag,
	output logic      [15:0] subSecond
);

	// Backup-domain reset release; system reset does not reach this block
	logic [1:0]  rstPipe_r;
	wire         rstSyncN;

	logic        kSync;
	logic        tsSync;
	logic        kPrev_r;
	logic        tsPrev_r;
	wire         kStep;
	wire         tsEdge;

	logic        calibPlus_r;
	logic        cycle8s_r;
	logic        cycle16s_r;
	logic [8:0]  maskCnt_r;
	wire  [8:0]  maskCntEff;
	wire         cycle16Eff;
	logic [1:0]  stepCount;

	rtcshf_shift_t shState_r;
	rtcshf_shift_t shState_nxt;
	logic        pendAdd_r;
	logic [14:0] pendSub_r;
	rtcshf_ss_t  ss_r;
	rtcshf_ss_t  ss_nxt;
	rtcshf_ss_t  ssShifted;
	logic [16:0] step1;
	logic [16:0] step2;
	logic        tick_nxt;
	wire         applyShift;

	logic [22:0] tsTime_r;
	logic [15:0] tsDate_r;
	wire         tsFlag_nxt;

	logic [31:0] rdData_r;
	logic [31:0] rdMux;

	wire         selKey;
	wire         selCal;
	wire         selShift;
	wire         selTime;
	wire         selDate;
	wire         wrCal;
	wire         wrShift;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rstPipe_r <= 2'b00;
		else
			rstPipe_r <= {rstPipe_r[0], 1'b1};
	end

	assign rstSyncN = rstPipe_r[1];

	rtcshf_sync2 u_kernelSync
	(
		.clk      (clk),
		.rstSyncN (rstSyncN),
		.d        (kernelClockPin),
		.q        (kSync)
	);

	rtcshf_sync2 u_tsSync
	(
		.clk      (clk),
		.rstSyncN (rstSyncN),
		.d        (tsEventPin),
		.q        (tsSync)
	);

	assign kStep  = kSync && !kPrev_r;
	assign tsEdge = tsSync && !tsPrev_r;

	always_ff @(posedge clk or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			kPrev_r  <= 1'b0;
			tsPrev_r <= 1'b0;
		end
		else if (ce)
		begin
			kPrev_r  <= kSync;
			tsPrev_r <= tsSync;
		end
	end

	// Address decode
	assign selKey   = addr == `RTCSHF_OFF_KEY;
	assign selCal   = addr == `RTCSHF_OFF_CALIB;
	assign selShift = addr == `RTCSHF_OFF_SHIFT;
	assign selTime  = addr == `RTCSHF_OFF_TSTIME;
	assign selDate  = addr == `RTCSHF_OFF_TSDATE;

	assign wrCal   = wrStb && selCal && writeUnlocked;
	assign wrShift = wrStb && selShift && writeUnlocked
	                 && (shState_r == SHF_IDLE);

	// Key byte goes out to the unlock logic and is never stored for readback
	always_ff @(posedge clk or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			keyByte   <= 8'h00;
			keyStrobe <= 1'b0;
		end
		else if (ce)
		begin
			keyStrobe <= wrStb && selKey;
			if (wrStb && selKey)
				keyByte <= wrData[`RTCSHF_KEY_MSB:0];
		end
	end

	// Calibration register
	always_ff @(posedge clk or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			calibPlus_r <= 1'b0;
			cycle8s_r   <= 1'b0;
			cycle16s_r  <= 1'b0;
			maskCnt_r   <= 9'h000;
		end
		else if (ce && wrCal)
		begin
			calibPlus_r <= wrData[`RTCSHF_CAL_PLUS_BIT];
			cycle8s_r   <= wrData[`RTCSHF_CAL_W8_BIT];
			cycle16s_r  <= wrData[`RTCSHF_CAL_W16_BIT];
			maskCnt_r   <= wrData[`RTCSHF_CAL_MASK_MSB:0];
		end
	end

	// Eight-second select wins if software breaks the exclusive-select rule
	assign cycle16Eff = cycle16s_r && !cycle8s_r;
	assign maskCntEff = cycle8s_r  ? {maskCnt_r[8:2], 2'b00} :
	                    cycle16Eff ? {maskCnt_r[8:1], 1'b0} :
	                    maskCnt_r;

	rtcshf_calib u_calib
	(
		.clk              (clk),
		.ce               (ce),
		.rstSyncN         (rstSyncN),
		.kStep            (kStep),
		.calibPlus        (calibPlus_r),
		.cycle8sSel       (cycle8s_r),
		.cycle16sSel      (cycle16Eff),
		.maskedPulseCount (maskCntEff),
		.stepCount        (stepCount)
	);

	// One prescaler step: returns {second boundary, next count}
	function automatic logic [16:0] ssStep
	(
		input rtcshf_ss_t  v,
		input logic [14:0] div
	);
		if (v == 16'h0000)
			ssStep = {1'b1, 1'b0, div};
		else
			ssStep = {1'b0, v - 16'h0001};
	endfunction : ssStep

	// Pending shift lands on the next kernel step, so count and shift stay atomic
	assign applyShift = (shState_r == SHF_PEND) && kStep;
	assign ssShifted  = applyShift ? ss_r + {1'b0, pendSub_r} : ss_r;

	always_comb
	begin
		step1    = ssStep(ssShifted, syncPrescalerDiv);
		step2    = ssStep(step1[15:0], syncPrescalerDiv);
		ss_nxt   = ssShifted;
		tick_nxt = 1'b0;
		case (stepCount)
			2'd1:
			begin
				ss_nxt   = step1[15:0];
				tick_nxt = step1[16];
			end
			2'd2:
			begin
				ss_nxt   = step2[15:0];
				tick_nxt = step1[16] || step2[16];
			end
			default:
			begin
				ss_nxt   = ssShifted;
				tick_nxt = 1'b0;
			end
		endcase
	end

	always_comb
	begin
		shState_nxt = shState_r;
		case (shState_r)
			SHF_IDLE:
				if (wrShift)
					shState_nxt = SHF_PEND;
			SHF_PEND:
				if (kStep)
					shState_nxt = SHF_SETTLE;
			SHF_SETTLE:
				if (kStep)
					shState_nxt = SHF_IDLE;
			default:
				shState_nxt = SHF_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			shState_r      <= SHF_IDLE;
			pendAdd_r      <= 1'b0;
			pendSub_r      <= 15'h0000;
			ss_r           <= 16'h0000;
			secondTick     <= 1'b0;
			addSecondTick  <= 1'b0;
			shadowSyncFlag <= 1'b0;
		end
		else if (ce)
		begin
			shState_r     <= shState_nxt;
			ss_r          <= ss_nxt;
			secondTick    <= tick_nxt;
			addSecondTick <= applyShift && pendAdd_r;
			if (wrShift)
			begin
				pendAdd_r      <= wrData[`RTCSHF_SHF_ADD_BIT];
				pendSub_r      <= wrData[`RTCSHF_SHF_SUB_MSB:0];
				shadowSyncFlag <= 1'b0;
			end
			else if (shState_r == SHF_SETTLE && kStep)
				shadowSyncFlag <= 1'b1;
			else if (shState_r == SHF_IDLE && kStep)
				shadowSyncFlag <= 1'b1;
		end
	end

	assign shiftPendingFlag = shState_r != SHF_IDLE;
	assign subSecond        = ss_r;

	// Timestamp capture; a new event beats a clear in the same cycle
	assign tsFlag_nxt = tsEdge || (timestampFlag && !tsFlagClear);

	always_ff @(posedge clk or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			timestampFlag <= 1'b0;
			tsTime_r      <= 23'h000000;
			tsDate_r      <= 16'h0000;
		end
		else if (ce)
		begin
			timestampFlag <= tsFlag_nxt;
			if (tsEdge)
			begin
				tsTime_r <= calTime;
				tsDate_r <= calDate;
			end
			else if (tsFlagClear)
			begin
				tsTime_r <= 23'h000000;
				tsDate_r <= 16'h0000;
			end
		end
	end

	// Read mux; key and shift registers read as zero, reserved bits zero
	always_comb
	begin
		rdMux = `RTCSHF_RST_WORD;
		if (selCal)
		begin
			rdMux[`RTCSHF_CAL_PLUS_BIT]     = calibPlus_r;
			rdMux[`RTCSHF_CAL_W8_BIT]       = cycle8s_r;
			rdMux[`RTCSHF_CAL_W16_BIT]      = cycle16s_r;
			rdMux[`RTCSHF_CAL_MASK_MSB:0]   = maskCntEff;
		end
		else if (selTime)
			rdMux[`RTCSHF_TIME_MSB:0] = tsTime_r;
		else if (selDate)
			rdMux[`RTCSHF_DATE_MSB:0] = tsDate_r;
		else if (selKey || selShift)
			rdMux = `RTCSHF_RST_WORD;
		else
			rdMux = `RTCSHF_RST_WORD;
	end

	always_ff @(posedge clk or negedge rstSyncN)
	begin
		if (!rstSyncN)
			rdData_r <= `RTCSHF_RST_WORD;
		else if (ce)
			rdData_r <= rdStb ? rdMux : `RTCSHF_RST_WORD;
	end

	assign rdData = rdData_r;

endmodule : rtcshf_top

// file: design/rtcshf_defines.svh
// Register map, field positions and reset values
`ifndef RTCSHF_DEFINES_SVH
`define RTCSHF_DEFINES_SVH

`define RTCSHF_OFF_KEY       8'h24
`define RTCSHF_OFF_CALIB     8'h28
`define RTCSHF_OFF_SHIFT     8'h2c
`define RTCSHF_OFF_TSTIME    8'h30
`define RTCSHF_OFF_TSDATE    8'h34

`define RTCSHF_RST_WORD      32'h0000_0000

`define RTCSHF_CAL_PLUS_BIT  15
`define RTCSHF_CAL_W8_BIT    14
`define RTCSHF_CAL_W16_BIT   13
`define RTCSHF_CAL_MASK_MSB  8
`define RTCSHF_SHF_ADD_BIT   31
`define RTCSHF_SHF_SUB_MSB   14
`define RTCSHF_KEY_MSB       7
`define RTCSHF_TIME_MSB      22
`define RTCSHF_DATE_MSB      15

`define RTCSHF_INSERT_PHASE  11'h400
`define RTCSHF_MASK_PHASE    11'h000

`endif

// file: design/rtcshf_pkg.sv
// Types shared by the shift logic and the sub-second counter
package rtcshf_pkg;

	typedef enum logic [1:0]
	{
		SHF_IDLE,
		SHF_PEND,
		SHF_SETTLE
	} rtcshf_shift_t;

	typedef logic [15:0] rtcshf_ss_t;

endpackage : rtcshf_pkg

// file: design/rtcshf_sync2.sv
// Two-flop synchroniser for a pin that arrives from outside the clock domain
`timescale 1ns/1ps
module rtcshf_sync2
(
	input  wire logic clk,
	input  wire logic rstSyncN,
	input  wire logic d,
	output logic      q
);

	logic meta_r;

	always_ff @(posedge clk or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			meta_r <= 1'b0;
			q      <= 1'b0;
		end
		else
		begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule : rtcshf_sync2

// file: design/rtcshf_calib.sv
// Smooth calibration: masks and inserts kernel pulses over an 8, 16 or 32 second cycle
`timescale 1ns/1ps
`include "rtcshf_defines.svh"
module rtcshf_calib
	import rtcshf_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       ce,
	input  wire logic       rstSyncN,
	input  wire logic       kStep,
	input  wire logic       calibPlus,
	input  wire logic       cycle8sSel,
	input  wire logic       cycle16sSel,
	input  wire logic [8:0] maskedPulseCount,
	output logic      [1:0] stepCount
);

	logic [19:0] cyc_r;
	logic [8:0]  rev32;
	logic [7:0]  rev16;
	logic [6:0]  rev8;
	wire         maskSlot;
	wire         insertSlot;
	wire         maskHit;

	// Bit-reversed slot index spreads masked pulses evenly across the cycle
	always_comb
	begin
		for (int i = 0; i < 9; i++)
			rev32[i] = cyc_r[19 - i];
		for (int i = 0; i < 8; i++)
			rev16[i] = cyc_r[18 - i];
		for (int i = 0; i < 7; i++)
			rev8[i] = cyc_r[17 - i];
	end

	assign maskSlot   = cyc_r[10:0] == `RTCSHF_MASK_PHASE;
	assign insertSlot = cyc_r[10:0] == `RTCSHF_INSERT_PHASE;
	assign maskHit    = cycle8sSel  ? (rev8  < maskedPulseCount[8:2]) :
	                    cycle16sSel ? (rev16 < maskedPulseCount[8:1]) :
	                    (rev32 < maskedPulseCount);

	// Net per 2^20 pulses: 512 inserted when plus bit set, minus the mask count
	assign stepCount = !kStep ? 2'd0 :
	                   (maskSlot && maskHit) ? 2'd0 :
	                   (insertSlot && calibPlus) ? 2'd2 : 2'd1;

	always_ff @(posedge clk or negedge rstSyncN)
	begin
		if (!rstSyncN)
			cyc_r <= 20'h00000;
		else if (ce && kStep)
			cyc_r <= cyc_r + 20'h00001;
	end

endmodule : rtcshf_calib

// file: testbench/rtcshf_chk.sv
// Port-level checks of the register block
`timescale 1ns/1ps
module rtcshf_chk
	import rtcshf_pkg::*;
(
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic [7:0]  addr,
	input wire logic [31:0] wrData,
	input wire logic        wrStb,
	input wire logic        rdStb,
	input wire logic [31:0] rdData,
	input wire logic        writeUnlocked,
	input wire logic [7:0]  keyByte,
	input wire logic        keyStrobe,
	input wire logic        addSecondTick,
	input wire logic        shiftPendingFlag,
	input wire logic        shadowSyncFlag,
	input wire logic        timestampFlag
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	wire logic shfWr = wrStb && addr == 8'h2c && !shiftPendingFlag;
	property p_key;
		wrStb && addr == 8'h24 |=> keyStrobe && keyByte == $past(wrData[7:0]);
	endproperty
	a_key: assert property (p_key) else $error("key byte not taken");
	property p_key_rd;
		rdStb && addr == 8'h24 |=> rdData == 32'h0;
	endproperty
	a_key_rd: assert property (p_key_rd) else $error("key reads nonzero");
	property p_w8;
		rdStb && addr == 8'h28 |=> !(rdData[14] && rdData[1:0] != 2'h0);
	endproperty
	a_w8: assert property (p_w8) else $error("mask low bits not forced");
	property p_w16;
		rdStb && addr == 8'h28 |=> !(rdData[13] && rdData[0]);
	endproperty
	a_w16: assert property (p_w16) else $error("mask bit 0 not forced");
	property p_shf_rd;
		rdStb && addr == 8'h2c |=> rdData == 32'h0;
	endproperty
	a_shf_rd: assert property (p_shf_rd) else $error("shift reads nonzero");
	property p_take;
		shfWr && writeUnlocked |=> shiftPendingFlag && !shadowSyncFlag;
	endproperty
	a_take: assert property (p_take) else $error("shift write not taken");
	property p_lock;
		shfWr && !writeUnlocked |=> !shiftPendingFlag;
	endproperty
	a_lock: assert property (p_lock) else $error("locked write taken");
	property p_ts_clr;
		rdStb && (addr == 8'h30 || addr == 8'h34) && !timestampFlag |=> rdData == 32'h0;
	endproperty
	a_ts_clr: assert property (p_ts_clr) else $error("capture not cleared");
	property p_tsf;
		rdStb && addr == 8'h30 |=> rdData[31:23] == 9'h0 && !rdData[15] && !rdData[7];
	endproperty
	a_tsf: assert property (p_tsf) else $error("time reserved bits set");
	property p_tsd;
		rdStb && addr == 8'h34 |=> rdData[31:16] == 16'h0 && rdData[7:6] == 2'h0;
	endproperty
	a_tsd: assert property (p_tsd) else $error("date reserved bits set");
	property p_add;
		$rose(addSecondTick) |-> shiftPendingFlag;
	endproperty
	a_add: assert property (p_add) else $error("second added with no shift");
	c_shift: cover property (shfWr && writeUnlocked);
	c_add: cover property (addSecondTick);
	c_ts: cover property ($rose(timestampFlag));
endmodule : rtcshf_chk

bind rtcshf_top rtcshf_chk rtcshf_chk_i
(
	.clk(clk), .rstn(rstn), .addr(addr), .wrData(wrData), .wrStb(wrStb),
	.rdStb(rdStb), .rdData(rdData), .writeUnlocked(writeUnlocked),
	.keyByte(keyByte), .keyStrobe(keyStrobe), .addSecondTick(addSecondTick),
	.shiftPendingFlag(shiftPendingFlag), .shadowSyncFlag(shadowSyncFlag),
	.timestampFlag(timestampFlag)
);

// file: testbench/rtcshf_tb.sv
// Self-checking bench for the register block
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("mismatch at %0t: value %h", $time, g); end end
module testbench
	import rtcshf_pkg::*;
;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} rtcshf_row_t;
	rtcshf_row_t rows [6] = '{'{8'h28, 32'h8155, 32'h8155}, '{8'h28, 32'h41ff, 32'h41fc},
		'{8'h28, 32'h21ff, 32'h21fe}, '{8'h24, 32'hab, 32'h0}, '{8'h40, 32'h5, 32'h0},
		'{8'h28, 32'h1, 32'h1}};
	logic [7:0]  rstA [3] = '{8'h28, 8'h30, 8'h34};
	logic        clk = 1'b0, rstn = 1'b0, wrStb = 1'b0, rdStb = 1'b0;
	logic        writeUnlocked = 1'b1, kernelClockPin = 1'b0;
	logic        tsEventPin = 1'b0, tsFlagClear = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wrData = 32'h0, rdv;
	logic [22:0] calTime = 23'h52_3459;
	logic [15:0] calDate = 16'ha519;
	wire logic [31:0] rdData;
	wire logic [7:0]  keyByte;
	wire logic        keyStrobe, addSecondTick, shiftPendingFlag, shadowSyncFlag, timestampFlag;
	wire logic        secondTick;
	wire logic [15:0] subSecond;
	int          fail_count = 0, total_checks = 0, addCnt = 0, tickCnt = 0;
	rtcshf_top rtcshf_top_i
	(
		.clk(clk), .ce(1'b1), .rstn(rstn), .addr(addr), .wrData(wrData), .wrStb(wrStb),
		.rdStb(rdStb), .rdData(rdData), .writeUnlocked(writeUnlocked),
		.kernelClockPin(kernelClockPin), .tsEventPin(tsEventPin), .tsFlagClear(tsFlagClear),
		.calTime(calTime), .calDate(calDate), .syncPrescalerDiv(15'h00ff), .keyByte(keyByte),
		.keyStrobe(keyStrobe), .secondTick(secondTick), .addSecondTick(addSecondTick),
		.shiftPendingFlag(shiftPendingFlag), .shadowSyncFlag(shadowSyncFlag),
		.timestampFlag(timestampFlag), .subSecond(subSecond)
	);
	always #12.5 clk = ~clk;
	always @(posedge clk)
	begin
		if (addSecondTick === 1'b1)
			addCnt++;
		if (secondTick === 1'b1)
			tickCnt++;
	end
	task report_and_stop;
		$display("checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wrData <= d;
		wrStb <= 1'b1;
		@(posedge clk);
		wrStb <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rdStb <= 1'b1;
		@(posedge clk);
		rdStb <= 1'b0;
		@(negedge clk);
		rdv = rdData;
	endtask : rd
	// One kernel pulse, long enough for the two-flop synchroniser
	task kp;
		kernelClockPin <= 1'b1;
		repeat (4) @(posedge clk);
		kernelClockPin <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : kp
	initial
	begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		foreach (rstA[i])
		begin
			rd(rstA[i]);
			`CHK(rdv, 32'h0)
		end
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a);
			`CHK(rdv, rows[i].e)
		end
		`CHK(keyByte, 8'hab)
		writeUnlocked <= 1'b0;
		wr(8'h28, 32'h8000);
		wr(8'h2c, 32'h8000_0000);
		rd(8'h28);
		`CHK(rdv, 32'h1)
		`CHK(shiftPendingFlag, 1'b0)
		writeUnlocked <= 1'b1;
		// Mask count 1 swallows the pulse in slot 0, so the count stays at zero
		kp;
		`CHK(subSecond, 16'h0000)
		wr(8'h2c, 32'h8000_0005);
		@(negedge clk);
		`CHK(shiftPendingFlag, 1'b1)
		`CHK(shadowSyncFlag, 1'b0)
		wr(8'h2c, 32'h8000_0000);
		rd(8'h2c);
		`CHK(rdv, 32'h0)
		repeat (4) kp;
		`CHK(addCnt, 1)
		`CHK(subSecond, 16'h0001)
		`CHK(tickCnt, 0)
		`CHK(shiftPendingFlag, 1'b0)
		`CHK(shadowSyncFlag, 1'b1)
		tsEventPin <= 1'b1;
		repeat (6) @(posedge clk);
		@(negedge clk);
		`CHK(timestampFlag, 1'b1)
		calTime <= 23'h0;
		rd(8'h30);
		`CHK(rdv, 32'h52_3459)
		rd(8'h34);
		`CHK(rdv, 32'ha519)
		tsFlagClear <= 1'b1;
		@(posedge clk);
		tsFlagClear <= 1'b0;
		tsEventPin <= 1'b0;
		rd(8'h30);
		`CHK(rdv, 32'h0)
		`CHK(timestampFlag, 1'b0)
		wr(8'h28, 32'h8155);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		rd(8'h28);
		`CHK(rdv, 32'h0)
		// After reset the count underflows on the first pulse and marks a second
		kp;
		`CHK(tickCnt, 1)
		`CHK(subSecond, 16'h00ff)
		report_and_stop;
	end
	// The sequence needs well under a thousand cycles
	initial
	begin
		#75000;
		fail_count++;
		report_and_stop;
	end
endmodule : testbench
